// ---- logic/dfc_consts.vh ----
/*
  Constants of the drive frequency command block: register byte offsets,
  reset values, terminal function codes and timing figures.
  Assumes a 32-bit Avalon-MM register bus and frequencies in 0.01 Hz units.
*/
`ifndef DFC_CONSTS_VH
`define DFC_CONSTS_VH

// register byte offsets
`define DFC_REG_CTRL 6'h00
`define DFC_REG_FSEL_LO 6'h04
`define DFC_REG_FSEL_HI 6'h08
`define DFC_REG_JOG 6'h0C
`define DFC_REG_MAX 6'h10
`define DFC_REG_START 6'h14
`define DFC_REG_STEP 6'h18
`define DFC_REG_SAVED 6'h1C
`define DFC_REG_DWELL 6'h20
`define DFC_REG_BASE 6'h24
`define DFC_REG_STATUS 6'h28

// control field positions
`define DFC_CTRL_METHOD_LSB 0
`define DFC_CTRL_SAVE_BIT 4
`define DFC_CTRL_MODE_LSB 5

// reset values, 0.01 Hz per count
`define DFC_RST_CTRL 8'h00
`define DFC_RST_FSEL_LO 32'h03020100
`define DFC_RST_FSEL_HI 32'h07060504
`define DFC_RST_JOG 16'h03E8
`define DFC_RST_MAX 16'h1770
`define DFC_RST_START 16'h0032
`define DFC_RST_STEP 16'h0000
`define DFC_RST_SAVED 16'h0000
`define DFC_RST_DWELL 16'h01F4
`define DFC_RST_BASE 16'h0000
`define DFC_FREQ_CEIL 16'h9C40

// frequency setting method and up-down modes
`define DFC_METHOD_UPDOWN 4'h8
`define DFC_MODE_HOLD 2'h0
`define DFC_MODE_STEP 2'h1
`define DFC_MODE_COMBO 2'h2

// terminal function codes
`define DFC_FN_FWD_RUN 5'h00
`define DFC_FN_REV_RUN 5'h01
`define DFC_FN_JOG 5'h04
`define DFC_FN_UP 5'h0F
`define DFC_FN_DOWN 5'h10
`define DFC_FN_3WIRE 5'h11
`define DFC_FN_CLEAR 5'h19
`define DFC_FN_JOG_FWD 5'h1A
`define DFC_FN_JOG_REV 5'h1B

// timing
`define DFC_CLK_KHZ 25000
`define DFC_HOLD_MS 3000
`define DFC_FILT_MS 1
`define DFC_RAMP_MS 1
`define DFC_HOLD_CYC (`DFC_HOLD_MS * `DFC_CLK_KHZ)
`define DFC_FILT_CYC (`DFC_FILT_MS * `DFC_CLK_KHZ)
`define DFC_RAMP_CYC (`DFC_RAMP_MS * `DFC_CLK_KHZ)

`endif

// ---- logic/dfc_freq_command.v ----
/*
  Frequency-reference command logic fed by eight multi-function terminals:
  jog, forward/reverse jog, up-down drive in three modes, 3-wire run latch.
  Assumes terminals are asynchronous pins and that a register master on
  sys_clk speaks Avalon-MM with waitrequest; the output feeds a later
  accel/decel and limit stage.
*/
`timescale 1ns/10ps
`include "dfc_consts.vh"

module dfc_freq_command #(
  parameter HOLD_CYC = `DFC_HOLD_CYC,
  parameter FILT_CYC = `DFC_FILT_CYC,
  parameter RAMP_CYC = `DFC_RAMP_CYC
) (
  input wire sys_clk,
  input wire rst,
  input wire [5:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  input wire [7:0] multi_function_inputs,
  input wire dwell_active,
  output reg [15:0] freq_ref_r,
  output reg run_r,
  output reg dir_rev_r,
  output reg jog_active_r
);
  // registers
  reg [7:0] ctrl_r;
  reg [31:0] fsel_lo_r;
  reg [31:0] fsel_hi_r;
  reg [15:0] jog_frequency_param;
  reg [15:0] maximum_frequency_param;
  reg [15:0] start_frequency_param;
  reg [15:0] updown_step_size;
  reg [15:0] updown_saved_frequency;
  reg [15:0] dwell_freq_r;
  reg [15:0] base_freq_r;
  // terminal front end
  reg [7:0] sync1_r;
  reg [7:0] sync2_r;
  reg [7:0] samp1_r;
  reg [7:0] samp2_r;
  reg [7:0] filt_r;
  reg [31:0] filt_cnt_r;
  reg [31:0] ramp_cnt_r;
  reg [31:0] hold_cnt_r;
  reg ramp_tick_r;
  reg [7:0] prev_r;
  reg [15:0] updown_ref_r;
  reg run_lat_r;
  reg lat_rev_r;
  reg run_prev_r;
  reg [15:0] target;
  reg [15:0] jog_nxt;
  wire [3:0] updown_method = ctrl_r[`DFC_CTRL_METHOD_LSB +: 4];
  wire updown_save_enable = ctrl_r[`DFC_CTRL_SAVE_BIT];
  wire [1:0] updown_mode_select = ctrl_r[`DFC_CTRL_MODE_LSB +: 2];
  wire [63:0] fsel_all = {fsel_hi_r, fsel_lo_r}; // one byte per terminal, code in bits 4:0
  // which terminals carry a given function code
  function [7:0] code_mask;
    input [63:0] sel;
    input [4:0] code;
    integer i;
    begin
      code_mask = 8'h00;
      for (i = 0; i < 8; i = i + 1) begin
        code_mask[i] = (sel[i*8 +: 5] == code);
      end
    end
  endfunction

  // saturating add and subtract against a limit
  function [15:0] sat_add;
    input [15:0] a;
    input [15:0] b;
    input [15:0] lim;
    reg [16:0] s;
    begin
      s = {1'b0, a} + {1'b0, b};
      sat_add = (s > {1'b0, lim}) ? lim : s[15:0];
    end
  endfunction
  function [15:0] sat_sub;
    input [15:0] a;
    input [15:0] b;
    input [15:0] lim;
    reg [16:0] s;
    begin
      s = {1'b0, a} - {1'b0, b};
      sat_sub = (s[16] || (s[15:0] < lim)) ? lim : s[15:0];
    end
  endfunction
  // decoded terminal functions
  wire [7:0] m_up = code_mask(fsel_all, `DFC_FN_UP);
  wire [7:0] m_dn = code_mask(fsel_all, `DFC_FN_DOWN);
  wire [7:0] m_tw = code_mask(fsel_all, `DFC_FN_3WIRE);
  wire in_up = |(m_up & filt_r);
  wire in_dn = |(m_dn & filt_r);
  wire up_rise = |(m_up & filt_r & ~prev_r);
  wire dn_rise = |(m_dn & filt_r & ~prev_r);
  wire updn_fall = |((m_up | m_dn) & ~filt_r & prev_r);
  wire updn_def = |(m_up | m_dn);
  wire clr_rise = |(code_mask(fsel_all, `DFC_FN_CLEAR) & filt_r & ~prev_r);
  wire jog_plain = |(code_mask(fsel_all, `DFC_FN_JOG) & filt_r);
  wire jog_fwd = |(code_mask(fsel_all, `DFC_FN_JOG_FWD) & filt_r);
  wire jog_rev = |(code_mask(fsel_all, `DFC_FN_JOG_REV) & filt_r);
  wire fwd_lvl = |(code_mask(fsel_all, `DFC_FN_FWD_RUN) & filt_r);
  wire rev_lvl = |(code_mask(fsel_all, `DFC_FN_REV_RUN) & filt_r);
  wire fwd_rise = |(code_mask(fsel_all, `DFC_FN_FWD_RUN) & filt_r & ~prev_r);
  wire rev_rise = |(code_mask(fsel_all, `DFC_FN_REV_RUN) & filt_r & ~prev_r);
  wire tw_def = |m_tw;
  wire tw_on = |(m_tw & filt_r);
  wire jog_any = jog_plain | jog_fwd | jog_rev;
  wire updown_on = (updown_method == `DFC_METHOD_UPDOWN);
  wire run_cmd = tw_def ? run_lat_r : (fwd_lvl | rev_lvl);
  wire running = run_cmd | jog_any;
  wire settled = (freq_ref_r == updown_ref_r) || !run_r;
  wire held_long = (hold_cnt_r >= HOLD_CYC);
  wire ramp_mode = (updown_mode_select == `DFC_MODE_HOLD) ||
                   ((updown_mode_select == `DFC_MODE_COMBO) && held_long);

  // two-flop synchroniser, then a 3-sample filter on a slow tick
  always @(posedge sys_clk) begin
    if (rst) begin
      sync1_r <= 8'h00;
      sync2_r <= 8'h00;
      samp1_r <= 8'h00;
      samp2_r <= 8'h00;
      filt_r <= 8'h00;
      filt_cnt_r <= 32'h00000000;
    end else begin
      sync1_r <= multi_function_inputs;
      sync2_r <= sync1_r;
      if (filt_cnt_r >= FILT_CYC - 1) begin
        filt_cnt_r <= 32'h00000000;
        samp1_r <= sync2_r;
        samp2_r <= samp1_r;
        // a bit changes only after three equal samples, bounce is dropped
        filt_r <= (sync2_r & samp1_r & samp2_r) | (filt_r & (sync2_r | samp1_r | samp2_r));
      end else begin
        filt_cnt_r <= filt_cnt_r + 32'h00000001;
      end
    end
  end

  // the one ramp rate shared by every mode and by jog
  always @(posedge sys_clk) begin
    if (rst) begin
      ramp_cnt_r <= 32'h00000000;
      ramp_tick_r <= 1'b0;
    end else if (ramp_cnt_r >= RAMP_CYC - 1) begin
      ramp_cnt_r <= 32'h00000000;
      ramp_tick_r <= 1'b1;
    end else begin
      ramp_cnt_r <= ramp_cnt_r + 32'h00000001;
      ramp_tick_r <= 1'b0;
    end
  end

  // hold timer for the combined mode
  always @(posedge sys_clk) begin
    if (rst) begin
      hold_cnt_r <= 32'h00000000;
    end else if (!(in_up ^ in_dn)) begin
      hold_cnt_r <= 32'h00000000;
    end else if (!held_long) begin
      hold_cnt_r <= hold_cnt_r + 32'h00000001;
    end
  end

  // 3-wire latch: pulses set the run state, opening the 3-wire input stops
  always @(posedge sys_clk) begin
    if (rst) begin
      run_lat_r <= 1'b0;
      lat_rev_r <= 1'b0;
    end else if (!tw_on) begin
      run_lat_r <= 1'b0;
    end else if (fwd_rise | rev_rise) begin
      run_lat_r <= 1'b1;
      lat_rev_r <= rev_rise; // relies on pulses of 50 ms or more
    end
  end

  // reference selection, dwell first, then jog, then up-down or base
  always @* begin
    target = 16'h0000;
    if (!running) begin
      target = 16'h0000;
    end else if (dwell_active) begin
      target = dwell_freq_r;
    end else if (jog_any) begin
      target = jog_frequency_param;
    end else if (updown_on) begin
      target = updown_ref_r;
    end else begin
      target = base_freq_r;
    end
  end

  // output stage moves toward the target one count per ramp tick
  always @(posedge sys_clk) begin
    if (rst) begin
      freq_ref_r <= 16'h0000;
      run_r <= 1'b0;
      dir_rev_r <= 1'b0;
      jog_active_r <= 1'b0;
      run_prev_r <= 1'b0;
      prev_r <= 8'h00;
    end else begin
      prev_r <= filt_r;
      run_prev_r <= run_cmd;
      run_r <= running;
      jog_active_r <= jog_any & ~dwell_active;
      if (jog_fwd | jog_rev) begin
        dir_rev_r <= jog_rev;
      end else if (tw_def) begin
        dir_rev_r <= lat_rev_r;
      end else begin
        dir_rev_r <= rev_lvl & ~fwd_lvl;
      end
      if (ramp_tick_r && freq_ref_r < target) begin
        freq_ref_r <= freq_ref_r + 16'h0001;
      end else if (ramp_tick_r && freq_ref_r > target) begin
        freq_ref_r <= freq_ref_r - 16'h0001;
      end
    end
  end

  // jog frequency write is accepted only inside start..max
  always @* begin
    jog_nxt = jog_frequency_param;
    if (avs_writedata[15:0] >= start_frequency_param &&
        avs_writedata[15:0] <= maximum_frequency_param) begin
      jog_nxt = avs_writedata[15:0];
    end
  end

  // register file, up-down reference and stored frequency
  always @(posedge sys_clk) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
      ctrl_r <= `DFC_RST_CTRL;
      fsel_lo_r <= `DFC_RST_FSEL_LO;
      fsel_hi_r <= `DFC_RST_FSEL_HI;
      jog_frequency_param <= `DFC_RST_JOG;
      maximum_frequency_param <= `DFC_RST_MAX;
      start_frequency_param <= `DFC_RST_START;
      updown_step_size <= `DFC_RST_STEP;
      updown_saved_frequency <= `DFC_RST_SAVED;
      dwell_freq_r <= `DFC_RST_DWELL;
      base_freq_r <= `DFC_RST_BASE;
      updown_ref_r <= 16'h0000;
    end else begin
      // one wait cycle: data prepared first, write lands when wait drops
      if ((avs_read | avs_write) && avs_waitrequest) begin
        avs_waitrequest <= 1'b0;
        if (avs_address == `DFC_REG_CTRL) begin
          avs_readdata <= {24'h000000, 1'b0, ctrl_r[6:0]};
        end else if (avs_address == `DFC_REG_FSEL_LO) begin
          avs_readdata <= fsel_lo_r & 32'h1F1F1F1F;
        end else if (avs_address == `DFC_REG_FSEL_HI) begin
          avs_readdata <= fsel_hi_r & 32'h1F1F1F1F;
        end else if (avs_address == `DFC_REG_JOG) begin
          avs_readdata <= {16'h0000, jog_frequency_param};
        end else if (avs_address == `DFC_REG_MAX) begin
          avs_readdata <= {16'h0000, maximum_frequency_param};
        end else if (avs_address == `DFC_REG_START) begin
          avs_readdata <= {16'h0000, start_frequency_param};
        end else if (avs_address == `DFC_REG_STEP) begin
          avs_readdata <= {16'h0000, updown_step_size};
        end else if (avs_address == `DFC_REG_SAVED) begin
          avs_readdata <= {16'h0000, updown_saved_frequency};
        end else if (avs_address == `DFC_REG_DWELL) begin
          avs_readdata <= {16'h0000, dwell_freq_r};
        end else if (avs_address == `DFC_REG_BASE) begin
          avs_readdata <= {16'h0000, base_freq_r};
        end else if (avs_address == `DFC_REG_STATUS) begin
          avs_readdata <= {filt_r, run_r, dir_rev_r, jog_active_r, 5'h00, freq_ref_r};
        end else begin
          avs_readdata <= 32'h00000000;
        end
      end else begin
        avs_waitrequest <= 1'b1;
      end
      if (avs_write && !avs_waitrequest) begin
        if (avs_address == `DFC_REG_CTRL) begin
          ctrl_r <= {1'b0, avs_writedata[6:0]};
        end else if (avs_address == `DFC_REG_FSEL_LO) begin
          fsel_lo_r <= avs_writedata & 32'h1F1F1F1F;
        end else if (avs_address == `DFC_REG_FSEL_HI) begin
          fsel_hi_r <= avs_writedata & 32'h1F1F1F1F;
        end else if (avs_address == `DFC_REG_JOG) begin
          jog_frequency_param <= jog_nxt;
        end else if (avs_address == `DFC_REG_MAX) begin
          maximum_frequency_param <= sat_add(avs_writedata[15:0], 16'h0000, `DFC_FREQ_CEIL);
        end else if (avs_address == `DFC_REG_START) begin
          start_frequency_param <= avs_writedata[15:0];
        end else if (avs_address == `DFC_REG_STEP) begin
          updown_step_size <= sat_add(avs_writedata[15:0], 16'h0000, `DFC_FREQ_CEIL);
        end else if (avs_address == `DFC_REG_SAVED) begin
          updown_saved_frequency <= avs_writedata[15:0];
        end else if (avs_address == `DFC_REG_DWELL) begin
          dwell_freq_r <= avs_writedata[15:0];
        end else if (avs_address == `DFC_REG_BASE) begin
          base_freq_r <= avs_writedata[15:0];
        end
      end
      // up-down reference; steps and ramps frozen while jog or dwell has the output, run-start reload is not
      if (updown_on && run_cmd && !run_prev_r && updown_save_enable) begin
        updown_ref_r <= updown_saved_frequency; // restart from the stored value
      end else if (updown_on && run_cmd && !jog_any && !dwell_active) begin
        if (ramp_mode && ramp_tick_r && in_up && !in_dn) begin
          updown_ref_r <= sat_add(updown_ref_r, 16'h0001, maximum_frequency_param);
        end else if (ramp_mode && ramp_tick_r && in_dn && !in_up) begin
          updown_ref_r <= sat_sub(updown_ref_r, 16'h0001, start_frequency_param);
        end
        if (updown_mode_select != `DFC_MODE_HOLD && settled) begin
          if (up_rise && !in_dn) begin
            updown_ref_r <= sat_add(updown_ref_r, updown_step_size, maximum_frequency_param);
          end else if (dn_rise && !in_up) begin
            updown_ref_r <= sat_sub(updown_ref_r, updown_step_size, start_frequency_param);
          end
        end
      end
      // stored frequency: hardware events placed last so they beat a write
      if (updown_on && updown_save_enable) begin
        if (clr_rise && !in_up && !in_dn) begin
          updown_saved_frequency <= 16'h0000;
          updown_ref_r <= 16'h0000;
        end else if (updown_mode_select == `DFC_MODE_STEP && updn_fall && updn_def) begin
          updown_saved_frequency <= updown_ref_r;
        end else if (updown_mode_select != `DFC_MODE_STEP && !run_cmd && run_prev_r) begin
          updown_saved_frequency <= updown_ref_r; // step mode keeps it
        end
      end
    end
  end

endmodule // dfc_freq_command

// ---- tb/dfc_freq_command_sva.sv ----
/*
  Checker for the frequency command block: bus handshake, ramp and jog relations.
  Assumes it sees only the top module's ports, one clock, synchronous reset.
*/
`timescale 1ns/10ps
module dfc_freq_command_sva #(
  parameter HOLD_CYC = 200,
  parameter FILT_CYC = 2,
  parameter RAMP_CYC = 4
) (
  input wire sys_clk,
  input wire rst,
  input wire [5:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  input wire [7:0] multi_function_inputs,
  input wire dwell_active,
  input wire [15:0] freq_ref_r,
  input wire run_r,
  input wire dir_rev_r,
  input wire jog_active_r
);
  logic [15:0] gap_r;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // cycles since the reference last moved, saturating so it never wraps
  always @(posedge sys_clk) begin
    if (rst || $changed(freq_ref_r)) gap_r <= 16'h0000;
    else if (gap_r != 16'hFFFF) gap_r <= gap_r + 16'h0001;
  end
  a_wait_after_req: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("waitrequest stayed high after a request");
  a_wait_one_low: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_wait_has_cause: assert property (!avs_waitrequest |-> $past(avs_read || avs_write))
    else $error("waitrequest dropped without a request");
  a_rdata_holds: assert property (!((avs_read || avs_write) && avs_waitrequest)
    |=> $stable(avs_readdata)) else $error("readdata changed outside an access");
  a_ramp_one_count: assert property (!$past(rst) && $changed(freq_ref_r) |->
    (freq_ref_r - $past(freq_ref_r) == 16'h0001) || ($past(freq_ref_r) - freq_ref_r == 16'h0001))
    else $error("reference moved by more than one count");
  a_ramp_gap_kept: assert property (!$past(rst) && $changed(freq_ref_r) |->
    gap_r >= RAMP_CYC - 1) else $error("reference moved faster than the ramp tick");
  a_jog_runs: assert property (jog_active_r |-> run_r)
    else $error("jog active without run");
  a_dwell_over_jog: assert property (dwell_active |=> !jog_active_r)
    else $error("jog active during dwell");
endmodule // dfc_freq_command_sva

bind dfc_freq_command dfc_freq_command_sva #(.HOLD_CYC(HOLD_CYC), .FILT_CYC(FILT_CYC),
  .RAMP_CYC(RAMP_CYC)) u_sva (.sys_clk(sys_clk), .rst(rst), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .multi_function_inputs(multi_function_inputs), .dwell_active(dwell_active),
  .freq_ref_r(freq_ref_r), .run_r(run_r), .dir_rev_r(dir_rev_r), .jog_active_r(jog_active_r));

// ---- tb/dfc_button_panel.sv ----
/*
  Push-button panel driving the eight terminals, levels changed after a clock edge.
  Assumes the caller scales the minimum pulse to the shortened filter timing.
*/
`timescale 1ns/10ps
module dfc_button_panel #(
  parameter int PULSE_MIN = 100
) (
  input wire sys_clk,
  output logic [7:0] multi_function_inputs
);
  initial multi_function_inputs = 8'h00;
  // hold a switch at a level
  task level(input int i, input logic v);
    @(posedge sys_clk);
    multi_function_inputs[i] <= v;
  endtask
  // a press never shorter than the minimum, so 3-wire pulses are always legal
  task tap(input int i, input int cyc);
    level(i, 1'b1);
    repeat ((cyc < PULSE_MIN) ? PULSE_MIN : cyc) @(posedge sys_clk);
    multi_function_inputs[i] <= 1'b0;
  endtask
endmodule // dfc_button_panel

// ---- tb/drive_frequency_command_inputs_test.sv ----
/*
  Self-checking bench for the frequency command block: register reads are noted in
  a queue and compared by a monitor. Assumes short filter, hold and ramp counts.
*/
`timescale 1ns/10ps
`include "dfc_consts.vh"
module drive_frequency_command_inputs_test;
  logic sys_clk, rst, avs_read, avs_write, dwell_active;
  logic [5:0] avs_address;
  logic [31:0] avs_writedata, r, pw;
  wire [31:0] avs_readdata;
  wire avs_waitrequest, run_r, dir_rev_r, jog_active_r;
  wire [15:0] freq_ref_r;
  wire [7:0] multi_function_inputs;
  logic [69:0] exp_q[$];
  logic [69:0] x;
  logic [31:0] rv [10];
  logic [15:0] jog;
  int jt [3];
  integer errors = 0, tests_run = 0, seed = 32'hb235, i;
  dfc_freq_command #(.HOLD_CYC(200), .FILT_CYC(2), .RAMP_CYC(4)) u_dut (.sys_clk(sys_clk),
    .rst(rst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .multi_function_inputs(multi_function_inputs),
    .dwell_active(dwell_active), .freq_ref_r(freq_ref_r), .run_r(run_r),
    .dir_rev_r(dir_rev_r), .jog_active_r(jog_active_r));
  dfc_button_panel #(.PULSE_MIN(100)) u_panel (.sys_clk(sys_clk),
    .multi_function_inputs(multi_function_inputs));
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  task results();
    if (errors == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // one access, held until waitrequest is seen low
  task bus(input logic wr, input [5:0] a, input [31:0] d);
    @(posedge sys_clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= d;
    @(posedge sys_clk);
    while (avs_waitrequest !== 1'b0) @(posedge sys_clk);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task rd(input [5:0] a, input [31:0] m, input [31:0] e);
    exp_q.push_back({a, m, e});
    bus(1'b0, a, 32'h00000000);
  endtask
  // bounded wait; a reference that never arrives shows up in the next read
  task wait_freq(input [15:0] f);
    integer n;
    n = 0;
    repeat (12) @(posedge sys_clk);
    while (freq_ref_r !== f && n < 30000) begin
      @(posedge sys_clk);
      n = n + 1;
    end
  endtask
  task settle(input [7:0] t, input [2:0] rdj, input [15:0] f);
    wait_freq(f);
    rd(`DFC_REG_STATUS, 32'hFFE0FFFF, {t, rdj, 5'h00, f});
  endtask
  // read data taken at the edge that ends the access
  always @(posedge sys_clk) begin
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
      x = exp_q.pop_front();
      tests_run = tests_run + 1;
      if ((avs_readdata & x[63:32]) !== x[31:0]) begin
        errors = errors + 1;
        $display("unexpected readdata at %h: expected %h, seen %h", x[69:64], x[31:0],
          avs_readdata & x[63:32]);
      end
      // the output ports must agree with the status word while it is read
      if (x[69:64] == `DFC_REG_STATUS) begin
        tests_run = tests_run + 1;
        pw = {8'h00, run_r, dir_rev_r, jog_active_r, 5'h00, freq_ref_r} & x[63:32];
        if (pw !== (x[31:0] & 32'h00FFFFFF)) begin
          errors = errors + 1;
          $display("unexpected output ports: expected %h, seen %h", x[31:0] & 32'h00FFFFFF, pw);
        end
      end
    end
  end
  initial begin
    repeat (100000) @(posedge sys_clk);
    errors = errors + 1;
    results();
  end
  initial begin
    rst = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 6'h00;
    avs_writedata = 32'h00000000;
    dwell_active = 1'b0;
    rv = '{{24'h0, `DFC_RST_CTRL}, `DFC_RST_FSEL_LO, `DFC_RST_FSEL_HI, {16'h0, `DFC_RST_JOG},
      {16'h0, `DFC_RST_MAX}, {16'h0, `DFC_RST_START}, {16'h0, `DFC_RST_STEP},
      {16'h0, `DFC_RST_SAVED}, {16'h0, `DFC_RST_DWELL}, {16'h0, `DFC_RST_BASE}};
    jt = '{4, 6, 7};
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    for (i = 0; i < 10; i = i + 1) rd(6'(i * 4), 32'hFFFFFFFF, rv[i]);
    bus(1'b1, 6'h3C, 32'hFFFFFFFF);
    rd(6'h3C, 32'hFFFFFFFF, 32'h00000000);
    // jog values below start or above maximum are refused
    bus(1'b1, `DFC_REG_JOG, 32'h00000031);
    rd(`DFC_REG_JOG, 32'h0000FFFF, 32'h000003E8);
    bus(1'b1, `DFC_REG_JOG, 32'h00001771);
    rd(`DFC_REG_JOG, 32'h0000FFFF, 32'h000003E8);
    r = $random(seed);
    jog = 16'h0032 + {7'h00, r[8:0]};
    bus(1'b1, `DFC_REG_JOG, {16'h0000, jog});
    rd(`DFC_REG_JOG, 32'h0000FFFF, {16'h0000, jog});
    bus(1'b1, `DFC_REG_MAX, 32'h0000FFFF);
    rd(`DFC_REG_MAX, 32'h0000FFFF, {16'h0000, `DFC_FREQ_CEIL});
    bus(1'b1, `DFC_REG_MAX, 32'h000005DC);
    bus(1'b1, `DFC_REG_FSEL_LO, 32'h19100F00);
    bus(1'b1, `DFC_REG_FSEL_HI, 32'h1B1A0104);
    // plain, forward and reverse jog; dwell cut into the plain one
    for (i = 0; i < 3; i = i + 1) begin
      u_panel.level(jt[i], 1'b1);
      settle(8'(1 << jt[i]), {1'b1, i == 2, 1'b1}, jog);
      if (i == 0) begin
        dwell_active <= 1'b1;
        settle(8'h10, 3'b100, 16'h01F4);
        dwell_active <= 1'b0;
        settle(8'h10, 3'b101, jog);
      end
      u_panel.level(jt[i], 1'b0);
      wait_freq(16'h0000);
      rd(`DFC_REG_STATUS, 32'h00A0FFFF, 32'h00000000);
    end
    // up-down step mode with saving, jog taking over meanwhile
    bus(1'b1, `DFC_REG_STEP, 32'h00000064);
    bus(1'b1, `DFC_REG_SAVED, 32'h000003E8);
    bus(1'b1, `DFC_REG_CTRL, 32'h00000038);
    u_panel.level(0, 1'b1);
    settle(8'h01, 3'b100, 16'h03E8);
    u_panel.level(4, 1'b1);
    settle(8'h11, 3'b101, jog);
    u_panel.level(4, 1'b0);
    settle(8'h01, 3'b100, 16'h03E8);
    u_panel.tap(1, 100);
    settle(8'h01, 3'b100, 16'h044C);
    rd(`DFC_REG_SAVED, 32'h0000FFFF, 32'h0000044C);
    u_panel.tap(2, 100);
    settle(8'h01, 3'b100, 16'h03E8);
    rd(`DFC_REG_SAVED, 32'h0000FFFF, 32'h000003E8);
    // second press while the first step is still ramping
    u_panel.tap(1, 100);
    repeat (20) @(posedge sys_clk);
    u_panel.tap(1, 100);
    wait_freq(16'h044C);
    repeat (600) @(posedge sys_clk);
    rd(`DFC_REG_STATUS, 32'h0000FFFF, 32'h0000044C);
    // clear is ignored while increase is held, honoured after
    u_panel.level(1, 1'b1);
    u_panel.tap(3, 100);
    u_panel.level(1, 1'b0);
    wait_freq(16'h04B0);
    rd(`DFC_REG_SAVED, 32'h0000FFFF, 32'h000004B0);
    u_panel.tap(3, 100);
    rd(`DFC_REG_SAVED, 32'h0000FFFF, 32'h00000000);
    wait_freq(16'h0000);
    // combined mode: one step, then a held ramp up to maximum
    bus(1'b1, `DFC_REG_CTRL, 32'h00000058);
    u_panel.tap(1, 100);
    settle(8'h01, 3'b100, 16'h0064);
    u_panel.level(1, 1'b1);
    wait_freq(16'h05DC);
    u_panel.level(1, 1'b0);
    settle(8'h01, 3'b100, 16'h05DC);
    // hold mode: decrease ramps down to start, stop saves it
    bus(1'b1, `DFC_REG_CTRL, 32'h00000018);
    u_panel.level(2, 1'b1);
    wait_freq(16'h0032);
    u_panel.level(2, 1'b0);
    settle(8'h01, 3'b100, 16'h0032);
    u_panel.level(0, 1'b0);
    wait_freq(16'h0000);
    rd(`DFC_REG_SAVED, 32'h0000FFFF, 32'h00000032);
    // other setting method: reverse run at the base reference, increase has no effect
    bus(1'b1, `DFC_REG_CTRL, 32'h00000030);
    bus(1'b1, `DFC_REG_BASE, 32'h00000064);
    u_panel.level(5, 1'b1);
    u_panel.tap(1, 100);
    settle(8'h20, 3'b110, 16'h0064);
    // 3-wire: a pulse latches run, dropping the 3-wire input stops
    u_panel.level(5, 1'b0);
    wait_freq(16'h0000);
    bus(1'b1, `DFC_REG_FSEL_HI, 32'h1B1A1104);
    u_panel.level(5, 1'b1);
    u_panel.tap(0, 100);
    settle(8'h20, 3'b100, 16'h0064);
    u_panel.level(5, 1'b0);
    settle(8'h00, 3'b000, 16'h0000);
    // let the monitor finish the last comparison before the verdict
    repeat (2) @(posedge sys_clk);
    results();
  end
endmodule // drive_frequency_command_inputs_test
